// file: include/csdsc_defs.vh
// Purpose: constants for the clock synthesizer divider and spread config block
// Assumes: 50 MHz clock_i, byte-indexed configuration writes
// Notes: definitions only
`ifndef CSDSC_DEFS_VH
`define CSDSC_DEFS_VH

// ------------------------------------------------------------
// register byte indices
// ------------------------------------------------------------
`define CSDSC_IDX_SPREAD    8'h14
`define CSDSC_IDX_RSVD_A    8'h15
`define CSDSC_IDX_GB_DIV    8'h16
`define CSDSC_IDX_RSP_LO    8'h17
`define CSDSC_IDX_RSP_HI    8'h18
`define CSDSC_IDX_MN_LO     8'h19
`define CSDSC_IDX_N_HI      8'h1A
`define CSDSC_IDX_CL_DIV    8'h1B
`define CSDSC_IDX_CSP_LO    8'h1C
`define CSDSC_IDX_CSP_HI    8'h1D
`define CSDSC_IDX_REF_DIV   8'h1E
`define CSDSC_IDX_RSVD_B    8'h1F
`define CSDSC_IDX_BCOUNT    8'h0B

// ------------------------------------------------------------
// writable masks and reset values
// ------------------------------------------------------------
`define CSDSC_MASK_SPREAD   8'h80
`define CSDSC_MASK_REF_DIV  8'h8F
`define CSDSC_MASK_BCOUNT   8'h3F
`define CSDSC_RST_ZERO      8'h00
`define CSDSC_RST_BCOUNT    8'h0F
`define CSDSC_RST_BC_FIELD  6'h0F
`define CSDSC_RST_RATIO     7'h02

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CSDSC_CLK_MHZ       50
`define CSDSC_CORE_EN_US    300
`define CSDSC_STAB_US       1800
// pin sync and wake entry cost a few cycles; taken off so both bounds hold at the pin
`define CSDSC_SYNC_CYC      8
`define CSDSC_CORE_EN_CYC   (`CSDSC_CORE_EN_US * `CSDSC_CLK_MHZ - `CSDSC_SYNC_CYC)
`define CSDSC_STAB_CYC      (`CSDSC_STAB_US * `CSDSC_CLK_MHZ - `CSDSC_SYNC_CYC)
`define CSDSC_CNT_W         17

`endif

// file: rtl/csdsc_div_decode.v
// Purpose: translate a 4-bit post-divider code into a divide ratio
// Assumes: combinational, used per output group
// Notes: restricted tables flag codes 1 to 3 as not available
`timescale 1ns/1ns

module csdsc_div_decode (
    input wire [3:0] code_i,
    input wire [1:0] table_i,
    output reg [6:0] ratio_o,
    output reg valid_o
);

// ------------------------------------------------------------
// table select: 0 ref (odd 7/14/..), 1 ref restricted, 2 core, 3 core restricted
// ------------------------------------------------------------
reg [6:0] base;
reg [6:0] row0;
reg [13:0] prod;

// row multiplier from the upper two code bits, bottom-row ratio from the lower two
always @* begin
    case (code_i[1:0])
        2'b00: row0 = 7'h02;
        2'b01: row0 = 7'h03;
        2'b10: row0 = 7'h05;
        default: row0 = table_i[1] ? 7'h09 : 7'h07;
    endcase
    case (code_i[3:2])
        2'b00: base = 7'h01;
        2'b01: base = 7'h02;
        2'b10: base = 7'h04;
        default: base = 7'h08;
    endcase
    // bottom row is 2,3,5,7|9; each row above doubles the one below
    // widened product; the largest ratio, 72, still fits seven bits
    prod = {7'h00, base} * {7'h00, row0};
    ratio_o = prod[6:0];
    valid_o = !(table_i[0] && (code_i[3:2] == 2'b00) && (code_i[1:0] != 2'b00));
end

endmodule

// file: rtl/csdsc_config.v
// Purpose: configuration bytes 20 to 31 of a multi-output clock synthesizer
// Assumes: byte-indexed write/read port from an SMBus engine on clock_i
// Notes: decoded settings drive the analog side; timers model exit timing
//
// Summary of operation
// - byte 20 bit 7 enables spread, resets 0
// - graphics and serial dividers, codes 1-3 unavailable
// - bridge divider supports all sixteen codes
// - bytes 23/24 form reference spread profile
// - byte 25 bits 5:0 give M
// - N from byte 30/25/26 bits
// - M/N change scales graphics and bridge too
// - byte 27 core and link divider tables
// - bytes 28/29 form core spread profile
// - core outputs enabled within 300 us
// - first stable clock within 1.8 ms
// - byte count field resets to 0F
`timescale 1ns/1ns
`include "csdsc_defs.vh"

module csdsc_config #(
    parameter [16:0] CORE_EN_CYC = `CSDSC_CORE_EN_CYC,
    parameter [16:0] STAB_CYC = `CSDSC_STAB_CYC
) (
    input wire clock_i,
    input wire srst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire power_down_input_i,
    output reg [7:0] rdata_o,
    output reg [5:0] readback_byte_count_o,
    output reg spread_on_bit_o,
    output reg [15:0] ref_spread_profile_o,
    output reg [15:0] core_spread_profile_o,
    output reg [5:0] pll_feedback_m_o,
    output reg [10:0] pll_feedback_n_o,
    output reg [6:0] graphics_ratio_o,
    output reg [6:0] bridge_ratio_o,
    output reg [6:0] serial_ref_ratio_o,
    output reg [6:0] core_ratio_o,
    output reg [6:0] link_ratio_o,
    output reg code_invalid_o,
    output reg ref_vco_update_o,
    output reg core_out_en_o,
    output reg clk_stable_o
);

// ------------------------------------------------------------
// register storage
// ------------------------------------------------------------
reg [7:0] spread_switch_ctrl_r;
reg [7:0] graphics_bridge_divider_r;
reg [7:0] ref_spread_profile_low_r;
reg [7:0] ref_spread_profile_high_r;
reg [7:0] ref_pll_m_and_n_low_r;
reg [7:0] ref_pll_n_high_r;
reg [7:0] core_link_divider_r;
reg [7:0] core_spread_profile_low_r;
reg [7:0] core_spread_profile_high_r;
reg [7:0] ref_output_divider_r;
reg [7:0] byte_count_r;
// bytes 21 and 31 are reserved, so they get no storage at all

// writes by byte index; reserved bits masked off so they read back zero
always @(posedge clock_i) begin
    if (srst_i) begin
        spread_switch_ctrl_r <= `CSDSC_RST_ZERO;
        graphics_bridge_divider_r <= `CSDSC_RST_ZERO;
        ref_spread_profile_low_r <= `CSDSC_RST_ZERO;
        ref_spread_profile_high_r <= `CSDSC_RST_ZERO;
        ref_pll_m_and_n_low_r <= `CSDSC_RST_ZERO;
        ref_pll_n_high_r <= `CSDSC_RST_ZERO;
        core_link_divider_r <= `CSDSC_RST_ZERO;
        core_spread_profile_low_r <= `CSDSC_RST_ZERO;
        core_spread_profile_high_r <= `CSDSC_RST_ZERO;
        ref_output_divider_r <= `CSDSC_RST_ZERO;
        byte_count_r <= `CSDSC_RST_BCOUNT;
    end else if (wr_en_i) begin
        case (addr_i)
            `CSDSC_IDX_SPREAD: begin
                spread_switch_ctrl_r <= wdata_i & `CSDSC_MASK_SPREAD;
            end
            `CSDSC_IDX_GB_DIV: begin
                graphics_bridge_divider_r <= wdata_i;
            end
            `CSDSC_IDX_RSP_LO: begin
                ref_spread_profile_low_r <= wdata_i;
            end
            `CSDSC_IDX_RSP_HI: begin
                ref_spread_profile_high_r <= wdata_i;
            end
            `CSDSC_IDX_MN_LO: begin
                ref_pll_m_and_n_low_r <= wdata_i;
            end
            `CSDSC_IDX_N_HI: begin
                ref_pll_n_high_r <= wdata_i;
            end
            `CSDSC_IDX_CL_DIV: begin
                core_link_divider_r <= wdata_i;
            end
            `CSDSC_IDX_CSP_LO: begin
                core_spread_profile_low_r <= wdata_i;
            end
            `CSDSC_IDX_CSP_HI: begin
                core_spread_profile_high_r <= wdata_i;
            end
            `CSDSC_IDX_REF_DIV: begin
                ref_output_divider_r <= wdata_i & `CSDSC_MASK_REF_DIV;
            end
            `CSDSC_IDX_BCOUNT: begin
                byte_count_r <= wdata_i & `CSDSC_MASK_BCOUNT;
            end
            default: begin
                // reserved bytes 21 and 31 and unknown indices are ignored
            end
        endcase
    end
end

// ------------------------------------------------------------
// read mux, registered one cycle after rd_en_i
// ------------------------------------------------------------
reg [7:0] rdata_nxt;

// unknown and reserved indices read zero; a write in the same cycle
// is only seen by the next read, which keeps the mux off the write path
always @* begin
    case (addr_i)
        `CSDSC_IDX_SPREAD: rdata_nxt = spread_switch_ctrl_r;
        `CSDSC_IDX_GB_DIV: rdata_nxt = graphics_bridge_divider_r;
        `CSDSC_IDX_RSP_LO: rdata_nxt = ref_spread_profile_low_r;
        `CSDSC_IDX_RSP_HI: rdata_nxt = ref_spread_profile_high_r;
        `CSDSC_IDX_MN_LO: rdata_nxt = ref_pll_m_and_n_low_r;
        `CSDSC_IDX_N_HI: rdata_nxt = ref_pll_n_high_r;
        `CSDSC_IDX_CL_DIV: rdata_nxt = core_link_divider_r;
        `CSDSC_IDX_CSP_LO: rdata_nxt = core_spread_profile_low_r;
        `CSDSC_IDX_CSP_HI: rdata_nxt = core_spread_profile_high_r;
        `CSDSC_IDX_REF_DIV: rdata_nxt = ref_output_divider_r;
        `CSDSC_IDX_BCOUNT: rdata_nxt = byte_count_r;
        default: rdata_nxt = `CSDSC_RST_ZERO;
    endcase
end

always @(posedge clock_i) begin
    if (srst_i) begin
        rdata_o <= `CSDSC_RST_ZERO;
    end else if (rd_en_i) begin
        rdata_o <= rdata_nxt;
    end
end

// ------------------------------------------------------------
// divider decode, one shared leaf per group
// ------------------------------------------------------------
// table_i bit 0 marks codes 1 to 3 unavailable, bit 1 picks the core
// family (9/18/36/72) over the reference family (7/14/28/56);
// one leaf per group keeps each decode path short and independent
wire [6:0] gfx_ratio;
wire [6:0] brg_ratio;
wire [6:0] ser_ratio;
wire [6:0] cor_ratio;
wire [6:0] lnk_ratio;
wire gfx_ok;
wire brg_ok;
wire ser_ok;
wire cor_ok;
wire lnk_ok;

csdsc_div_decode u_gfx (
    .code_i(graphics_bridge_divider_r[7:4]),
    .table_i(2'b01),
    .ratio_o(gfx_ratio),
    .valid_o(gfx_ok)
);

csdsc_div_decode u_brg (
    .code_i(graphics_bridge_divider_r[3:0]),
    .table_i(2'b00),
    .ratio_o(brg_ratio),
    .valid_o(brg_ok)
);

csdsc_div_decode u_ser (
    .code_i(ref_output_divider_r[3:0]),
    .table_i(2'b01),
    .ratio_o(ser_ratio),
    .valid_o(ser_ok)
);

csdsc_div_decode u_cor (
    .code_i(core_link_divider_r[3:0]),
    .table_i(2'b10),
    .ratio_o(cor_ratio),
    .valid_o(cor_ok)
);

csdsc_div_decode u_lnk (
    .code_i(core_link_divider_r[7:4]),
    .table_i(2'b11),
    .ratio_o(lnk_ratio),
    .valid_o(lnk_ok)
);

// ------------------------------------------------------------
// registered settings toward the analog side
// ------------------------------------------------------------
wire [10:0] n_nxt;
wire [5:0] m_nxt;

assign n_nxt = {ref_pll_n_high_r, ref_pll_m_and_n_low_r[7:6], ref_output_divider_r[7]};
assign m_nxt = ref_pll_m_and_n_low_r[5:0];

// m or n moved since last cycle; either one retunes the shared vco
wire m_moved;
wire n_moved;

assign m_moved = (m_nxt != pll_feedback_m_o);
assign n_moved = (n_nxt != pll_feedback_n_o);

// an unavailable code keeps the previous ratio so the output never glitches
always @(posedge clock_i) begin
    if (srst_i) begin
        spread_on_bit_o <= 1'b0;
        ref_spread_profile_o <= 16'h0000;
        core_spread_profile_o <= 16'h0000;
        pll_feedback_m_o <= 6'h00;
        pll_feedback_n_o <= 11'h000;
        graphics_ratio_o <= `CSDSC_RST_RATIO;
        bridge_ratio_o <= `CSDSC_RST_RATIO;
        serial_ref_ratio_o <= `CSDSC_RST_RATIO;
        core_ratio_o <= `CSDSC_RST_RATIO;
        link_ratio_o <= `CSDSC_RST_RATIO;
        code_invalid_o <= 1'b0;
        ref_vco_update_o <= 1'b0;
        readback_byte_count_o <= `CSDSC_RST_BC_FIELD;
    end else begin
        spread_on_bit_o <= spread_switch_ctrl_r[7];
        ref_spread_profile_o <= {ref_spread_profile_high_r, ref_spread_profile_low_r};
        core_spread_profile_o <= {core_spread_profile_high_r, core_spread_profile_low_r};
        pll_feedback_m_o <= m_nxt;
        pll_feedback_n_o <= n_nxt;
        // shared vco: graphics and bridge follow any m/n change
        ref_vco_update_o <= m_moved || n_moved;
        if (gfx_ok) begin
            graphics_ratio_o <= gfx_ratio;
        end
        bridge_ratio_o <= brg_ratio;
        if (ser_ok) begin
            serial_ref_ratio_o <= ser_ratio;
        end
        core_ratio_o <= cor_ratio;
        if (lnk_ok) begin
            link_ratio_o <= lnk_ratio;
        end
        code_invalid_o <= !(gfx_ok && brg_ok && ser_ok && cor_ok && lnk_ok);
        readback_byte_count_o <= byte_count_r[5:0];
    end
end

// ------------------------------------------------------------
// power-down input synchroniser, three stages
// ------------------------------------------------------------
reg pd_s1_r;
reg pd_s2_r;
reg pd_s3_r;
reg pd_level_r;

// stage one is read only by stage two
// reset to the powered-down level so no false wake follows reset
always @(posedge clock_i) begin
    if (srst_i) begin
        pd_s1_r <= 1'b1;
        pd_s2_r <= 1'b1;
        pd_s3_r <= 1'b1;
        pd_level_r <= 1'b1;
    end else begin
        pd_s1_r <= power_down_input_i;
        pd_s2_r <= pd_s1_r;
        pd_s3_r <= pd_s2_r;
        if (pd_s2_r == pd_s3_r) begin
            pd_level_r <= pd_s3_r;
        end
    end
end

// ------------------------------------------------------------
// exit timers after reset or power-down release
// ------------------------------------------------------------
localparam [2:0] ST_OFF = 3'b001;
localparam [2:0] ST_WAKE = 3'b010;
localparam [2:0] ST_RUN = 3'b100;

// one counter serves both bounds; it restarts from zero on every
// power-down exit, so a short pd pulse never shortens the next wait
reg [2:0] state_r;
reg [`CSDSC_CNT_W-1:0] wake_cnt_r;

// core outputs wait far less than the first-clock bound; each lands only a few cycles inside its own bound
always @(posedge clock_i) begin
    if (srst_i) begin
        state_r <= ST_WAKE;
        wake_cnt_r <= {`CSDSC_CNT_W{1'b0}};
        core_out_en_o <= 1'b0;
        clk_stable_o <= 1'b0;
    end else begin
        case (state_r)
            ST_OFF: begin
                core_out_en_o <= 1'b0;
                clk_stable_o <= 1'b0;
                wake_cnt_r <= {`CSDSC_CNT_W{1'b0}};
                if (!pd_level_r) begin
                    state_r <= ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (pd_level_r) begin
                    state_r <= ST_OFF;
                end else begin
                    wake_cnt_r <= wake_cnt_r + 1'b1;
                    if (wake_cnt_r == CORE_EN_CYC - 1'b1) begin
                        core_out_en_o <= 1'b1;
                    end
                    if (wake_cnt_r == STAB_CYC - 1'b1) begin
                        clk_stable_o <= 1'b1;
                        state_r <= ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (pd_level_r) begin
                    state_r <= ST_OFF;
                    core_out_en_o <= 1'b0;
                    clk_stable_o <= 1'b0;
                end
            end
            default: begin
                state_r <= ST_OFF;
            end
        endcase
    end
end

endmodule

// file: testbench/csdsc_host_model.sv
// Purpose: byte-level host controller driving the config port
// Assumes: strobes change at the falling edge, taken on the next rising edge
// Notes: released address and data show the inverse, never a stale copy
`timescale 1ns/1ns
module csdsc_host_model (
    input wire clock_i,
    input wire [7:0] rdata_i,
    output reg wr_en_o,
    output reg rd_en_o,
    output reg [7:0] addr_o,
    output reg [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one byte write by index, held across exactly one rising edge
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock_i);
            wr_en_o = 1'b1;
            addr_o = a;
            wdata_o = d;
            @(negedge clock_i);
            wr_en_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~d;
        end
    endtask
    // one byte read; data stands until the next read, so sample late
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clock_i);
            rd_en_o = 1'b1;
            addr_o = a;
            @(negedge clock_i);
            rd_en_o = 1'b0;
            addr_o = ~a;
            @(negedge clock_i);
            d = rdata_i;
        end
    endtask
endmodule

// file: testbench/csdsc_config_asserts.sv
// Purpose: port-level assertions for the config block
// Assumes: timer parameters handed on by the bind
// Notes: pd low time counted at the raw pin, so sync delay adds slack to the early check and uses part of the 8-cycle late margin
`timescale 1ns/1ns
module csdsc_config_asserts #(
    parameter [16:0] CORE_EN_CYC = 17'h00014,
    parameter [16:0] STAB_CYC = 17'h00032
) (
    input wire clock_i,
    input wire srst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire power_down_input_i,
    input wire [7:0] rdata_o,
    input wire [5:0] readback_byte_count_o,
    input wire spread_on_bit_o,
    input wire [15:0] ref_spread_profile_o,
    input wire [15:0] core_spread_profile_o,
    input wire [5:0] pll_feedback_m_o,
    input wire [10:0] pll_feedback_n_o,
    input wire code_invalid_o,
    input wire core_out_en_o,
    input wire clk_stable_o
);
    // ------------------------------------------------------------
    // pd low counter
    // ------------------------------------------------------------
    reg [16:0] low_cnt_r;
    // saturates so a long idle run never wraps into an early count
    always @(posedge clock_i) begin
        if (srst_i || power_down_input_i) begin
            low_cnt_r <= 17'h00000;
        end else if (low_cnt_r != 17'h1FFFF) begin
            low_cnt_r <= low_cnt_r + 17'h00001;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    sequence s_wr(a);
        wr_en_i && addr_i == a;
    endsequence
    // read of the spread byte, then a quiet cycle so the data stands
    sequence s_rd_spread;
        (rd_en_i && addr_i == 8'h14) ##1 !rd_en_i;
    endsequence
    a_spread_bit_follow: assert property (disable iff (srst_i)
        s_wr(8'h14) |-> ##2 spread_on_bit_o == $past(wdata_i[7], 2)) else $error("spread bit");
    a_ref_profile_low: assert property (disable iff (srst_i)
        s_wr(8'h17) |-> ##2 ref_spread_profile_o[7:0] == $past(wdata_i, 2)) else $error("ref lo");
    a_core_profile_high: assert property (disable iff (srst_i)
        s_wr(8'h1D) |-> ##2 core_spread_profile_o[15:8] == $past(wdata_i, 2)) else $error("core hi");
    a_m_value_follow: assert property (disable iff (srst_i)
        s_wr(8'h19) |-> ##2 pll_feedback_m_o == $past(wdata_i[5:0], 2)) else $error("m value");
    a_n_lsb_follow: assert property (disable iff (srst_i)
        s_wr(8'h1E) |-> ##2 pll_feedback_n_o[0] == $past(wdata_i[7], 2)) else $error("n lsb");
    a_bad_code_flag: assert property (disable iff (srst_i)
        wr_en_i && addr_i == 8'h16 && wdata_i[7:4] inside {4'h1, 4'h2, 4'h3}
        |-> ##2 code_invalid_o) else $error("code flag");
    a_rsvd_read_zero: assert property (disable iff (srst_i)
        s_rd_spread |-> rdata_o[6:0] == 7'h00) else $error("reserved bits");
    a_reset_values: assert property (srst_i ##1 srst_i
        |-> readback_byte_count_o == 6'h0F && !core_out_en_o) else $error("reset values");
    a_core_not_early: assert property (disable iff (srst_i)
        $rose(core_out_en_o) |-> low_cnt_r >= CORE_EN_CYC) else $error("core early");
    a_core_not_late: assert property (disable iff (srst_i)
        low_cnt_r == CORE_EN_CYC + 17'h00008 |-> core_out_en_o) else $error("core late");
    a_stable_not_late: assert property (disable iff (srst_i)
        low_cnt_r == STAB_CYC + 17'h00008 |-> clk_stable_o) else $error("stable late");
endmodule
bind csdsc_config csdsc_config_asserts #(.CORE_EN_CYC(CORE_EN_CYC), .STAB_CYC(STAB_CYC)) u_chk (
    .clock_i(clock_i), .srst_i(srst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .power_down_input_i(power_down_input_i),
    .rdata_o(rdata_o), .readback_byte_count_o(readback_byte_count_o),
    .spread_on_bit_o(spread_on_bit_o), .ref_spread_profile_o(ref_spread_profile_o),
    .core_spread_profile_o(core_spread_profile_o), .pll_feedback_m_o(pll_feedback_m_o),
    .pll_feedback_n_o(pll_feedback_n_o), .code_invalid_o(code_invalid_o),
    .core_out_en_o(core_out_en_o), .clk_stable_o(clk_stable_o));

// file: testbench/clock_synth_divider_spread_config_tb_top.sv
// Purpose: self-checking bench for the config block
// Assumes: short timers, 20 ns clock, reset held 10 cycles
// Notes: expected ratios come from the bench's own tables
`timescale 1ns/1ns
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin mismatches++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, act, exp); end end
module clock_synth_divider_spread_config_tb_top;
    localparam [16:0] CORE = 17'h00014;
    localparam [16:0] STAB = 17'h00032;
    logic clock_i = 1'b0, srst_i = 1'b1, pd = 1'b1, wr, rd, code_invalid, vco, core_en, stable;
    logic [7:0] addr, wdata, rdata, d;
    logic [5:0] bcount, m;
    logic spread;
    logic [15:0] rprof, cprof;
    logic [10:0] n;
    logic [6:0] g_r, b_r, s_r, c_r, l_r;
    int mismatches = 0, n_compared = 0, vco_cnt = 0;
    logic [6:0] br [16] = '{7'h02, 7'h03, 7'h05, 7'h07, 7'h04, 7'h06, 7'h0A, 7'h0E,
                            7'h08, 7'h0C, 7'h14, 7'h1C, 7'h10, 7'h18, 7'h28, 7'h38};
    logic [6:0] co [16] = '{7'h02, 7'h03, 7'h05, 7'h09, 7'h04, 7'h06, 7'h0A, 7'h12,
                            7'h08, 7'h0C, 7'h14, 7'h24, 7'h10, 7'h18, 7'h28, 7'h48};
    csdsc_host_model u_csdsc_host_model (.clock_i(clock_i), .rdata_i(rdata), .wr_en_o(wr),
        .rd_en_o(rd), .addr_o(addr), .wdata_o(wdata));
    csdsc_config #(.CORE_EN_CYC(CORE), .STAB_CYC(STAB)) u_csdsc_config (.clock_i(clock_i),
        .srst_i(srst_i), .wr_en_i(wr), .rd_en_i(rd), .addr_i(addr), .wdata_i(wdata),
        .power_down_input_i(pd), .rdata_o(rdata), .readback_byte_count_o(bcount),
        .spread_on_bit_o(spread), .ref_spread_profile_o(rprof), .core_spread_profile_o(cprof),
        .pll_feedback_m_o(m), .pll_feedback_n_o(n), .graphics_ratio_o(g_r),
        .bridge_ratio_o(b_r), .serial_ref_ratio_o(s_r), .core_ratio_o(c_r),
        .link_ratio_o(l_r), .code_invalid_o(code_invalid), .ref_vco_update_o(vco),
        .core_out_en_o(core_en), .clk_stable_o(stable));
    // ------------------------------------------------------------
    // clock, pulse counter, watchdog
    // ------------------------------------------------------------
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    // sampled at the falling edge so the pulse has settled
    always @(negedge clock_i) if (vco === 1'b1) vco_cnt++;
    // 5000 cycles is far beyond the whole sequence
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_vals();
        u_csdsc_host_model.rd(8'h14, d);
        `CHK(d, 8'h00)
        u_csdsc_host_model.rd(8'h0B, d);
        `CHK(d, 8'h0F)
        `CHK(core_en, 1'b0)
    endtask
    // reserved bits are written as ones and must read back zero
    task t_spread();
        u_csdsc_host_model.wr(8'h14, 8'h7F);
        u_csdsc_host_model.rd(8'h14, d);
        `CHK(d, 8'h00)
        `CHK(spread, 1'b0)
        u_csdsc_host_model.wr(8'h14, 8'hFF);
        u_csdsc_host_model.rd(8'h14, d);
        `CHK(d, 8'h80)
        `CHK(spread, 1'b1)
    endtask
    // every code in every group; codes 1 to 3 must leave the old ratio (2) in graphics, serial and link
    task t_dividers();
        logic bad;
        for (int i = 0; i < 16; i++) begin
            bad = (i >= 1 && i <= 3);
            u_csdsc_host_model.wr(8'h16, {i[3:0], i[3:0]});
            u_csdsc_host_model.wr(8'h1B, {i[3:0], i[3:0]});
            u_csdsc_host_model.wr(8'h1E, {4'h0, i[3:0]});
            repeat (2) @(negedge clock_i);
            `CHK(b_r, br[i])
            `CHK(c_r, co[i])
            `CHK(g_r, bad ? 7'h02 : br[i])
            `CHK(s_r, bad ? 7'h02 : br[i])
            `CHK(l_r, bad ? 7'h02 : co[i])
            `CHK(code_invalid, bad)
        end
    endtask
    task t_fields();
        int vco_base;
        vco_base = vco_cnt;
        u_csdsc_host_model.wr(8'h17, 8'h34);
        u_csdsc_host_model.wr(8'h18, 8'h12);
        u_csdsc_host_model.wr(8'h1C, 8'hCD);
        u_csdsc_host_model.wr(8'h1D, 8'hAB);
        u_csdsc_host_model.wr(8'h19, 8'hC5);
        u_csdsc_host_model.wr(8'h1A, 8'hA5);
        u_csdsc_host_model.wr(8'h1E, 8'hF0);
        u_csdsc_host_model.wr(8'h0B, 8'hFF);
        u_csdsc_host_model.rd(8'h1E, d);
        `CHK(d, 8'h80)
        `CHK(rprof, 16'h1234)
        `CHK(cprof, 16'hABCD)
        `CHK(m, 6'h05)
        `CHK(n, 11'h52F)
        `CHK(vco_cnt != vco_base, 1'b1)
        `CHK(bcount, 6'h3F)
    endtask
    task t_power();
        pd = 1'b0;
        repeat (10) @(negedge clock_i);
        `CHK(core_en, 1'b0)
        repeat (CORE - 2) @(negedge clock_i);
        `CHK(core_en, 1'b1)
        `CHK(stable, 1'b0)
        repeat (STAB - CORE) @(negedge clock_i);
        `CHK(stable, 1'b1)
        pd = 1'b1;
        repeat (8) @(negedge clock_i);
        `CHK({core_en, stable}, 2'b00)
    endtask
    initial begin
        repeat (10) @(negedge clock_i);
        srst_i = 1'b0;
        t_reset_vals();
        t_spread();
        t_dividers();
        t_fields();
        t_power();
        stop_test();
    end
endmodule
